// ### design/qssb_regs.svh
/*
  Register offsets, field positions, reset values and counts for the quad serial
  select, baud and interrupt front end. Assumes inclusion by bare name.
*/
`ifndef QSSB_REGS_SVH
`define QSSB_REGS_SVH

// ----------------------------------------------------------------------------
// Device address map (word index = paddr[9:2])
// ----------------------------------------------------------------------------
`define QSSB_ADDR_W 8
`define QSSB_UPPER_BIT 7
`define QSSB_CHAN_LSB 4
`define QSSB_CHAN_MSB 5
`define QSSB_IDX_MSB 3
`define QSSB_NCHAN 4

// Channel registers, index in channel_addr_bits window.
`define QSSB_CH_IER 4'h1
`define QSSB_CH_FCR 4'h2
`define QSSB_CH_DLL 4'h3
`define QSSB_CH_DLM 4'h4
`define QSSB_CH_MCR 4'h5
`define QSSB_CH_CFG 4'h6
`define QSSB_CH_TXTRIG 4'h7
`define QSSB_CH_RXTRIG 4'h8
`define QSSB_CH_STAT 4'h9

// Device registers in the upper region.
`define QSSB_DEV_RESET 8'h80
`define QSSB_DEV_BCAST 8'h81
`define QSSB_DEV_ISTAT 8'h82
`define QSSB_DEV_IMASK 8'h83

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define QSSB_IER_RX 0
`define QSSB_IER_TX 1
`define QSSB_FCR_FIFO_EN 0
`define QSSB_MCR_PRESCALE 7
`define QSSB_CFG_X8 0
`define QSSB_CFG_HALF_DUPLEX 1
`define QSSB_BCAST_EN 0

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define QSSB_RST_BYTE 8'h00
`define QSSB_RST_TRIG 7'h20
`define QSSB_PRESCALE_DIV4 2'h3
`define QSSB_SAMPLES_X16 5'h10
`define QSSB_SAMPLES_X8 5'h08

`endif

// ### design/qssb_pkg.sv
/*
  Types used by the front end; the baud generators do not import them.
  Assumes the constants header is compiled alongside.
*/
package qssb_pkg;

  typedef enum logic [0:0] {
    QSSB_ST_WAIT = 1'b0,
    QSSB_ST_DONE = 1'b1
  } qssb_apb_state_type;

  typedef logic [7:0] qssb_byte_type;

endpackage : qssb_pkg

// ### design/qssb_baud_if.sv
/*
  Carrier between the channel register file and one baud generator.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps

interface qssb_baud_if;
  logic [15:0] divisor;
  logic prescale_by4;
  logic rate_x8;
  logic chan_rst;
  logic sample_tick;
  logic bit_tick;

  modport ctl (output divisor, output prescale_by4, output rate_x8, output chan_rst,
               input sample_tick, input bit_tick);
  modport gen (input divisor, input prescale_by4, input rate_x8, input chan_rst,
               output sample_tick, output bit_tick);
endinterface : qssb_baud_if

// ### design/qssb_baud_gen.sv
/*
  One channel's prescaler and programmable divisor, shared by that channel's
  transmitter and receiver. Assumes clk is the oscillator clock.
*/
`timescale 1ns/1ps
`include "qssb_regs.svh"

module qssb_baud_gen (
  input wire logic clk,
  input wire logic rst_n,
  qssb_baud_if.gen bif
);

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  logic [1:0] pre_reg;
  logic [15:0] div_reg;
  logic [4:0] samp_reg;
  logic pre_tick;
  logic div_done;
  logic [4:0] samp_limit;

  assign pre_tick = !bif.prescale_by4 || (pre_reg == `QSSB_PRESCALE_DIV4);
  // A divisor of zero holds the generator still instead of running wild.
  assign div_done = pre_tick && (bif.divisor != 16'h0000) && (div_reg <= 16'h0001);
  assign samp_limit = bif.rate_x8 ? `QSSB_SAMPLES_X8 : `QSSB_SAMPLES_X16;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 2'h0;
    end else if (bif.chan_rst || !bif.prescale_by4 || pre_tick) begin
      pre_reg <= 2'h0;
    end else begin
      pre_reg <= pre_reg + 2'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Divisor and sample counter
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
    end else if (bif.chan_rst || div_done) begin
      div_reg <= bif.divisor;
    end else if (pre_tick && div_reg != 16'h0000) begin
      div_reg <= div_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bif.sample_tick <= 1'b0;
      bif.bit_tick <= 1'b0;
      samp_reg <= 5'h00;
    end else begin
      bif.sample_tick <= div_done && !bif.chan_rst;
      bif.bit_tick <= div_done && !bif.chan_rst && (samp_reg + 5'h01 >= samp_limit);
      if (bif.chan_rst || (div_done && samp_reg + 5'h01 >= samp_limit)) begin
        samp_reg <= 5'h00;
      end else if (div_done) begin
        samp_reg <= samp_reg + 5'h01;
      end
    end
  end

endmodule : qssb_baud_gen

// ### design/qssb_front.sv
/*
  APB front end of a four-channel serial device: channel select decode,
  broadcast write, per-channel soft reset, interrupt conditions and one
  baud generator per channel. Assumes the transmit and receive sections sit
  outside and report FIFO levels and empty flags synchronous to clk.
*/
// Notes on behaviour
// - Writing the reset register returns selected channels' registers to defaults.
// - Channel accesses occur only while chip select is low; otherwise ignored.
// - Upper address bit and bit six low: bits five and four pick channel; upper bit high selects device registers.
// - Broadcast bit set: a channel write updates that register in all four.
// - FIFO mode, no half-duplex: transmit request while level at or below trigger.
// - FIFO mode, half-duplex: transmit request at or below trigger or transmitter fully empty.
// - FIFO mode: receive request once receive level is above the trigger.
// - The oscillator clock runs every baud generator and the other logic.
// - Each channel has one baud generator shared by transmitter and receiver.
// - Modem control bit 7 selects prescale by 1 when clear, 4 when set.
// - The generator divides the prescaled clock by a divisor of 1 to 65535.
// - The sampling tick times transmit shifting and receive sampling.
// - The divisor is high byte then low byte, sixteen bits together.
// - Sampling-rate bit picks sixteen or eight samples per bit.
`timescale 1ns/1ps
`include "qssb_regs.svh"

module qssb_front (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_sel_b,
  input wire logic [27:0] tx_fifo_level,
  input wire logic [27:0] rx_fifo_level,
  input wire logic [3:0] tx_all_empty,
  input wire logic [3:0] thr_empty,
  input wire logic [3:0] rx_data_ready,
  output logic [3:0] sample_tick,
  output logic [3:0] bit_tick,
  output logic [3:0] chan_reset,
  output logic irq
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [6:0] level_of(input logic [27:0] bus, input int ch);
    level_of = bus[ch*7 +: 7];
  endfunction : level_of

  function automatic logic [7:0] pad7(input logic [6:0] v);
    pad7 = {1'b0, v};
  endfunction : pad7

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  qssb_pkg::qssb_apb_state_type state_reg;
  logic [7:0] dev_addr;
  logic [1:0] chan_sel;
  logic [3:0] reg_idx;
  logic access;
  logic commit;
  logic selected;
  logic chan_region;
  logic chan_mapped;
  logic dev_mapped;
  logic mapped;
  logic wr_commit;

  assign dev_addr = paddr[9:2];
  assign chan_sel = dev_addr[`QSSB_CHAN_MSB:`QSSB_CHAN_LSB];
  assign reg_idx = dev_addr[`QSSB_IDX_MSB:0];
  assign access = psel && penable;
  assign commit = access && (state_reg == qssb_pkg::QSSB_ST_DONE);
  assign selected = !chip_sel_b;
  assign chan_region = !dev_addr[`QSSB_UPPER_BIT] && (dev_addr[6] == 1'b0);
  assign chan_mapped = chan_region && (reg_idx >= `QSSB_CH_IER) && (reg_idx <= `QSSB_CH_STAT);
  assign dev_mapped = (dev_addr >= `QSSB_DEV_RESET) && (dev_addr <= `QSSB_DEV_IMASK);
  assign mapped = chan_mapped || dev_mapped;
  assign wr_commit = commit && pwrite && selected && (paddr[11:10] == 2'b00) && mapped;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= qssb_pkg::QSSB_ST_WAIT;
    end else begin
      case (state_reg)
        qssb_pkg::QSSB_ST_WAIT: begin
          if (access) begin
            state_reg <= qssb_pkg::QSSB_ST_DONE;
          end
        end
        qssb_pkg::QSSB_ST_DONE: begin
          state_reg <= qssb_pkg::QSSB_ST_WAIT;
        end
        default: begin
          state_reg <= qssb_pkg::QSSB_ST_WAIT;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Device registers
  // --------------------------------------------------------------------------
  logic [7:0] bcast_ctrl_reg;
  logic [7:0] istat_reg;
  logic [7:0] istat_next;
  logic [7:0] imask_reg;
  logic [3:0] soft_rst;
  logic bcast_on;
  logic wr_reset;
  logic wr_bcast;
  logic wr_istat;
  logic wr_imask;

  assign bcast_on = bcast_ctrl_reg[`QSSB_BCAST_EN];
  assign wr_reset = wr_commit && (dev_addr == `QSSB_DEV_RESET);
  assign wr_bcast = wr_commit && (dev_addr == `QSSB_DEV_BCAST);
  assign wr_istat = wr_commit && (dev_addr == `QSSB_DEV_ISTAT);
  assign wr_imask = wr_commit && (dev_addr == `QSSB_DEV_IMASK);
  assign soft_rst = wr_reset ? pwdata[3:0] : 4'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcast_ctrl_reg <= `QSSB_RST_BYTE;
      imask_reg <= `QSSB_RST_BYTE;
    end else begin
      if (wr_bcast) begin
        bcast_ctrl_reg <= pwdata[7:0];
      end
      if (wr_imask) begin
        imask_reg <= pwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Channel registers
  // --------------------------------------------------------------------------
  logic [7:0] ier_reg [`QSSB_NCHAN];
  logic [7:0] fifo_ctrl_reg [`QSSB_NCHAN];
  logic [7:0] divisor_low_byte [`QSSB_NCHAN];
  logic [7:0] divisor_high_byte [`QSSB_NCHAN];
  logic [7:0] modem_ctrl_reg [`QSSB_NCHAN];
  logic [7:0] cfg_reg [`QSSB_NCHAN];
  logic [6:0] txtrig_reg [`QSSB_NCHAN];
  logic [6:0] rxtrig_reg [`QSSB_NCHAN];
  logic [3:0] chan_wr;

  // Broadcast drops the channel bits so the same index lands in every channel.
  // Reads are not broadcast; software clears the bit before reading anyway.
  genvar gc;
  generate
    for (gc = 0; gc < `QSSB_NCHAN; gc++) begin : g_wr
      assign chan_wr[gc] = wr_commit && chan_mapped
        && (bcast_on || chan_sel == 2'(gc));
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < `QSSB_NCHAN; c++) begin
        ier_reg[c] <= `QSSB_RST_BYTE;
        fifo_ctrl_reg[c] <= `QSSB_RST_BYTE;
        divisor_low_byte[c] <= `QSSB_RST_BYTE;
        divisor_high_byte[c] <= `QSSB_RST_BYTE;
        modem_ctrl_reg[c] <= `QSSB_RST_BYTE;
        cfg_reg[c] <= `QSSB_RST_BYTE;
        txtrig_reg[c] <= `QSSB_RST_TRIG;
        rxtrig_reg[c] <= `QSSB_RST_TRIG;
      end
    end else begin
      for (int c = 0; c < `QSSB_NCHAN; c++) begin
        if (soft_rst[c]) begin
          ier_reg[c] <= `QSSB_RST_BYTE;
          fifo_ctrl_reg[c] <= `QSSB_RST_BYTE;
          divisor_low_byte[c] <= `QSSB_RST_BYTE;
          divisor_high_byte[c] <= `QSSB_RST_BYTE;
          modem_ctrl_reg[c] <= `QSSB_RST_BYTE;
          cfg_reg[c] <= `QSSB_RST_BYTE;
          txtrig_reg[c] <= `QSSB_RST_TRIG;
          rxtrig_reg[c] <= `QSSB_RST_TRIG;
        end else if (chan_wr[c]) begin
          case (reg_idx)
            `QSSB_CH_IER: ier_reg[c] <= pwdata[7:0];
            `QSSB_CH_FCR: fifo_ctrl_reg[c] <= pwdata[7:0];
            `QSSB_CH_DLL: divisor_low_byte[c] <= pwdata[7:0];
            `QSSB_CH_DLM: divisor_high_byte[c] <= pwdata[7:0];
            `QSSB_CH_MCR: modem_ctrl_reg[c] <= pwdata[7:0];
            `QSSB_CH_CFG: cfg_reg[c] <= pwdata[7:0];
            `QSSB_CH_TXTRIG: txtrig_reg[c] <= pwdata[6:0];
            `QSSB_CH_RXTRIG: rxtrig_reg[c] <= pwdata[6:0];
            default: begin
            end
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt conditions
  // --------------------------------------------------------------------------
  logic [3:0] tx_req;
  logic [3:0] rx_req;
  logic [7:0] req_now;
  logic [7:0] req_prev_reg;
  logic [7:0] req_rise;

  generate
    for (gc = 0; gc < `QSSB_NCHAN; gc++) begin : g_int
      logic fifo_on;
      logic half_dup;
      logic [6:0] txl;
      logic [6:0] rxl;
      logic tx_fifo_req;
      assign fifo_on = fifo_ctrl_reg[gc][`QSSB_FCR_FIFO_EN];
      assign half_dup = cfg_reg[gc][`QSSB_CFG_HALF_DUPLEX];
      assign txl = level_of(tx_fifo_level, gc);
      assign rxl = level_of(rx_fifo_level, gc);
      // Level at or below the transmit trigger means request; empty depends on half-duplex mode.
      assign tx_fifo_req = (txl <= txtrig_reg[gc])
        || (half_dup ? tx_all_empty[gc] : (txl == 7'h00));
      assign tx_req[gc] = ier_reg[gc][`QSSB_IER_TX]
        && (fifo_on ? tx_fifo_req : thr_empty[gc]);
      assign rx_req[gc] = ier_reg[gc][`QSSB_IER_RX]
        && (fifo_on ? (rxl > rxtrig_reg[gc]) : rx_data_ready[gc]);
      assign req_now[2*gc] = tx_req[gc];
      assign req_now[2*gc+1] = rx_req[gc];
    end
  endgenerate

  assign req_rise = req_now & ~req_prev_reg;
  // A new event in the cycle of a write-one clear keeps its bit set.
  assign istat_next = (istat_reg & ~(wr_istat ? pwdata[7:0] : 8'h00)) | req_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_prev_reg <= 8'h00;
      istat_reg <= 8'h00;
      irq <= 1'b0;
    end else begin
      req_prev_reg <= req_now;
      istat_reg <= istat_next;
      irq <= |(istat_next & imask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Baud generators
  // --------------------------------------------------------------------------
  qssb_baud_if bif [`QSSB_NCHAN] ();

  generate
    for (gc = 0; gc < `QSSB_NCHAN; gc++) begin : g_baud
      assign bif[gc].divisor = {divisor_high_byte[gc], divisor_low_byte[gc]};
      assign bif[gc].prescale_by4 = modem_ctrl_reg[gc][`QSSB_MCR_PRESCALE];
      assign bif[gc].rate_x8 = cfg_reg[gc][`QSSB_CFG_X8];
      assign bif[gc].chan_rst = soft_rst[gc];
      // One generator per channel feeds both directions.
      qssb_baud_gen u_gen (
        .clk(clk),
        .rst_n(rst_n),
        .bif(bif[gc])
      );
      assign sample_tick[gc] = bif[gc].sample_tick;
      assign bit_tick[gc] = bif[gc].bit_tick;
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_reset <= 4'h0;
    end else begin
      chan_reset <= soft_rst;
    end
  end

  // --------------------------------------------------------------------------
  // Read data and answer
  // --------------------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [7:0] rd_chan;

  always_comb begin
    rd_chan = 8'h00;
    case (reg_idx)
      `QSSB_CH_IER: rd_chan = ier_reg[chan_sel];
      `QSSB_CH_FCR: rd_chan = fifo_ctrl_reg[chan_sel];
      `QSSB_CH_DLL: rd_chan = divisor_low_byte[chan_sel];
      `QSSB_CH_DLM: rd_chan = divisor_high_byte[chan_sel];
      `QSSB_CH_MCR: rd_chan = modem_ctrl_reg[chan_sel];
      `QSSB_CH_CFG: rd_chan = cfg_reg[chan_sel];
      `QSSB_CH_TXTRIG: rd_chan = pad7(txtrig_reg[chan_sel]);
      `QSSB_CH_RXTRIG: rd_chan = pad7(rxtrig_reg[chan_sel]);
      `QSSB_CH_STAT: rd_chan = {6'h00, rx_req[chan_sel], tx_req[chan_sel]};
      default: rd_chan = 8'h00;
    endcase
  end

  always_comb begin
    rd_byte = 8'h00;
    if (chan_mapped) begin
      rd_byte = rd_chan;
    end else begin
      case (dev_addr)
        `QSSB_DEV_BCAST: rd_byte = bcast_ctrl_reg;
        `QSSB_DEV_ISTAT: rd_byte = istat_reg;
        `QSSB_DEV_IMASK: rd_byte = imask_reg;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // The answer comes one cycle into the access phase; a deselected cycle is
  // answered with zero data and no error so the bus never hangs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (access && state_reg == qssb_pkg::QSSB_ST_WAIT) begin
      pready <= 1'b1;
      prdata <= (selected && mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= selected && (!mapped || paddr[11:10] != 2'b00);
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

endmodule : qssb_front

// ### tb/qssb_serial_model.sv
/*
  Serial-side model: measures each channel's sampling tick period and the
  sampling ticks per bit. Assumes one-cycle tick pulses on clk.
*/
`timescale 1ns/1ps
module qssb_serial_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] sample_tick,
  input wire logic [3:0] bit_tick,
  output logic [3:0][19:0] tick_period,
  output logic [3:0][7:0] samples_per_bit
);
  logic [3:0][19:0] cnt_reg;
  logic [3:0][7:0] smp_reg;

  // ----------------------------------------------------------------
  // Tick timing
  // ----------------------------------------------------------------
  // A bit tick may coincide with its last sample, so that sample is added.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      smp_reg <= '0;
      tick_period <= '0;
      samples_per_bit <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        cnt_reg[c] <= sample_tick[c] ? 20'h1 : cnt_reg[c] + 20'h1;
        if (sample_tick[c]) begin
          tick_period[c] <= cnt_reg[c];
        end
        if (bit_tick[c]) begin
          samples_per_bit[c] <= smp_reg[c] + {7'h0, sample_tick[c]};
          smp_reg[c] <= 8'h0;
        end else begin
          smp_reg[c] <= smp_reg[c] + {7'h0, sample_tick[c]};
        end
      end
    end
  end
endmodule : qssb_serial_model

// ### tb/qssb_front_monitor.sv
/*
  Port-level checker of the serial front end, bound into the top module.
  Assumes the APB timing of one wait state given by the designer.
*/
`timescale 1ns/1ps
module qssb_front_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_sel_b,
  input wire logic [3:0] chan_reset,
  input wire logic irq
);
  logic [7:0] didx;
  logic done;
  assign didx = paddr[9:2];
  assign done = psel && penable && pready;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_PREADY_WAIT: assert property (psel && penable && !pready && $past(psel && !penable)
    |=> pready) else $error("pready not one cycle after access");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata outside answer");
  AST_CS_IGNORED: assert property (pready && chip_sel_b |-> !pslverr && prdata == 32'h0)
    else $error("deselected access answered");
  AST_RESERVED: assert property (pready && !chip_sel_b &&
    (didx[7:6] == 2'h1 || didx > 8'h83) |-> pslverr) else $error("reserved not refused");
  AST_CHAN_OK: assert property (pready && !chip_sel_b && paddr[11:10] == 2'h0 &&
    didx[7:6] == 2'h0 && didx[3:0] inside {[4'h1:4'h8]} |-> !pslverr)
    else $error("channel access refused");
  AST_SOFT_RESET: assert property (done && pwrite && !chip_sel_b && didx == 8'h80
    |=> chan_reset == $past(pwdata[3:0])) else $error("reset pulse wrong");
  AST_RESET_CAUSE: assert property (chan_reset != 4'h0
    |-> $past(done && pwrite && didx == 8'h80)) else $error("reset pulse uncaused");
  AST_IRQ_MASKED: assert property (done && pwrite && !chip_sel_b && didx == 8'h83 &&
    pwdata[7:0] == 8'h0 |-> ##2 !irq) else $error("irq with mask clear");

  cover property (chan_reset != 4'h0);
  cover property (done && pslverr);
  cover property ($rose(irq));
  cover property (pready && chip_sel_b);
endmodule : qssb_front_monitor

bind qssb_front qssb_front_monitor u_monitor (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .chip_sel_b(chip_sel_b), .chan_reset(chan_reset),
  .irq(irq));

// ### tb/test_quad_serial_select_baud_irq.sv
/*
  Testbench of the serial front end: APB tasks and scenario sequence.
  Assumes the design header and package are compiled first.
*/
`timescale 1ns/1ps
`include "qssb_regs.svh"
module test_quad_serial_select_baud_irq;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic chip_sel_b = 1'b0;
  logic [27:0] tx_lvl = {4{7'h40}}, rx_lvl = 28'h0;
  logic [3:0] tx_all_empty = 4'h0, thr_empty = 4'h0, rx_data_ready = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [3:0] sample_tick, bit_tick, chan_reset;
  logic [3:0][19:0] per;
  logic [3:0][7:0] spb;
  int miscompares = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  qssb_front DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_sel_b(chip_sel_b), .tx_fifo_level(tx_lvl), .rx_fifo_level(rx_lvl),
    .tx_all_empty(tx_all_empty), .thr_empty(thr_empty), .rx_data_ready(rx_data_ready),
    .sample_tick(sample_tick), .bit_tick(bit_tick), .chan_reset(chan_reset), .irq(irq));
  qssb_serial_model u_model (.clk(clk), .rst_b(rst_b), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .tick_period(per), .samples_per_bit(spb));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Read data and response are taken at the edge that samples pready high.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    bus(1'b1, idx, d, rd, e);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp,
                      input logic err);
    logic [31:0] rd;
    logic e;
    bus(1'b0, idx, 8'h0, rd, e);
    check(what, {24'h0, exp}, rd);
    check("pslverr", {31'h0, err}, {31'h0, e});
  endtask : rchk

  function automatic logic [7:0] ci(input int c, input logic [3:0] r);
    return {2'h0, 2'(c), r};
  endfunction : ci

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("tx trigger", ci(2, `QSSB_CH_TXTRIG), 8'h20, 1'b0);
    rchk("unmapped", 8'h84, 8'h0, 1'b1);
    rchk("reserved", 8'h41, 8'h0, 1'b1);
    for (int c = 0; c < 4; c++) wr(ci(c, `QSSB_CH_DLL), 8'(c + 1));
    for (int c = 0; c < 4; c++) rchk("dll", ci(c, `QSSB_CH_DLL), 8'(c + 1), 1'b0);
    @(posedge clk);
    chip_sel_b <= 1'b1;
    wr(ci(0, `QSSB_CH_DLL), 8'h55);
    rchk("deselected", ci(0, `QSSB_CH_DLL), 8'h0, 1'b0);
    @(posedge clk);
    chip_sel_b <= 1'b0;
    rchk("dll kept", ci(0, `QSSB_CH_DLL), 8'h1, 1'b0);
    wr(`QSSB_DEV_BCAST, 8'h1);
    wr(ci(2, `QSSB_CH_CFG), 8'h1);
    wr(`QSSB_DEV_BCAST, 8'h0);
    for (int c = 0; c < 4; c++) rchk("cfg", ci(c, `QSSB_CH_CFG), 8'h1, 1'b0);
    // Baud: ch0 x8 div 3, ch1 prescale 4 div 2, ch2 div 0x0900, ch3 div 1.
    wr(ci(0, `QSSB_CH_DLL), 8'h3);
    wr(ci(1, `QSSB_CH_CFG), 8'h0);
    wr(ci(1, `QSSB_CH_MCR), 8'h80);
    wr(ci(2, `QSSB_CH_CFG), 8'h0);
    wr(ci(2, `QSSB_CH_DLM), 8'h9);
    wr(ci(2, `QSSB_CH_DLL), 8'h0);
    wr(ci(3, `QSSB_CH_DLL), 8'h1);
    repeat (7200) @(posedge clk);
    check("period0", 32'h3, {12'h0, per[0]});
    check("period1", 32'h8, {12'h0, per[1]});
    check("period2", 32'h900, {12'h0, per[2]});
    check("period3", 32'h1, {12'h0, per[3]});
    check("samples0", 32'h8, {24'h0, spb[0]});
    check("samples1", 32'h10, {24'h0, spb[1]});
    wr(`QSSB_DEV_RESET, 8'h2);
    rchk("dll1 reset", ci(1, `QSSB_CH_DLL), 8'h0, 1'b0);
    rchk("mcr1 reset", ci(1, `QSSB_CH_MCR), 8'h0, 1'b0);
    rchk("dll0 kept", ci(0, `QSSB_CH_DLL), 8'h3, 1'b0);
    rchk("reset reg", `QSSB_DEV_RESET, 8'h0, 1'b0);
    wr(ci(0, `QSSB_CH_FCR), 8'h1);
    wr(ci(0, `QSSB_CH_IER), 8'h3);
    @(posedge clk);
    tx_lvl[6:0] <= 7'h21;
    rchk("istat", `QSSB_DEV_ISTAT, 8'h0, 1'b0);
    @(posedge clk);
    tx_lvl[6:0] <= 7'h20;
    rchk("istat", `QSSB_DEV_ISTAT, 8'h1, 1'b0);
    check("irq", 32'h0, {31'h0, irq});
    wr(`QSSB_DEV_IMASK, 8'h1);
    repeat (2) @(posedge clk);
    check("irq", 32'h1, {31'h0, irq});
    rchk("status0", ci(0, `QSSB_CH_STAT), 8'h1, 1'b0);
    @(posedge clk);
    rx_lvl[6:0] <= 7'h20;
    rchk("istat", `QSSB_DEV_ISTAT, 8'h1, 1'b0);
    @(posedge clk);
    rx_lvl[6:0] <= 7'h21;
    rchk("istat", `QSSB_DEV_ISTAT, 8'h3, 1'b0);
    wr(`QSSB_DEV_ISTAT, 8'h1);
    rchk("istat", `QSSB_DEV_ISTAT, 8'h2, 1'b0);
    check("irq", 32'h0, {31'h0, irq});
    wr(ci(1, `QSSB_CH_FCR), 8'h1);
    wr(ci(1, `QSSB_CH_CFG), 8'h2);
    wr(ci(1, `QSSB_CH_IER), 8'h2);
    wr(ci(2, `QSSB_CH_FCR), 8'h1);
    wr(ci(2, `QSSB_CH_IER), 8'h2);
    wr(ci(3, `QSSB_CH_IER), 8'h3);
    @(posedge clk);
    tx_all_empty <= 4'h6;
    thr_empty <= 4'h8;
    rx_data_ready <= 4'h8;
    rchk("istat", `QSSB_DEV_ISTAT, 8'hc6, 1'b0);
    wr(`QSSB_DEV_IMASK, 8'h80);
    rchk("istat", `QSSB_DEV_ISTAT, 8'hc6, 1'b0);
    check("irq", 32'h1, {31'h0, irq});
    wr(`QSSB_DEV_IMASK, 8'h0);
    wr(`QSSB_DEV_ISTAT, 8'hff);
    rchk("istat", `QSSB_DEV_ISTAT, 8'h0, 1'b0);
    check("irq", 32'h0, {31'h0, irq});
    report_and_stop();
  end
endmodule : test_quad_serial_select_baud_irq
